// ---- rtl/gaoc_consts.vh ----
// gaoc_consts.vh: constants for the gas alarm output control block
// assumes: included by bare name, 20 MHz pclk, 32-bit apb data
`ifndef GAOC_CONSTS_VH
`define GAOC_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GAOC_OFF_CTRL 12'h000
`define GAOC_OFF_SETPT 12'h004
`define GAOC_OFF_DELAY 12'h008
`define GAOC_OFF_SUPP 12'h00C
`define GAOC_OFF_CONC 12'h010
`define GAOC_OFF_STAT 12'h014
`define GAOC_OFF_LOOP 12'h018
`define GAOC_OFF_DISP 12'h01C
// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define GAOC_CTRL_DLY_EN 0
`define GAOC_CTRL_ALM_USE 1
`define GAOC_CTRL_MAINT 2
`define GAOC_CTRL_INHIBIT 3
`define GAOC_CTRL_ATEST 4
`define GAOC_CTRL_ATEST_OUT 5
`define GAOC_CTRL_MSEL_LO 6
`define GAOC_CTRL_MSEL_HI 7
`define GAOC_CTRL_FAULT_SET 8
`define GAOC_CTRL_FAULT_CLR 9
// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define GAOC_STAT_ALARM 0
`define GAOC_STAT_CONTACT 1
`define GAOC_STAT_FAULT 2
`define GAOC_STAT_INIT 3
`define GAOC_STAT_OVER 4
`define GAOC_STAT_PEND 5
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GAOC_CTRL_RST 32'h0000_0043
`define GAOC_SETPT_RST 16'h0FA0
`define GAOC_DELAY_MS_RST 16'h07D0
`define GAOC_SUPP_PCT_RST 7'h0A
`define GAOC_FULL_SCALE_RST 16'hFFFF
// ----------------------------------------------------------------
// maintenance output selections
// ----------------------------------------------------------------
`define GAOC_MSEL_2MA5 2'h0
`define GAOC_MSEL_4MA 2'h1
`define GAOC_MSEL_HOLD 2'h2
`define GAOC_MSEL_LIVE 2'h3
// ----------------------------------------------------------------
// loop currents in microamps
// ----------------------------------------------------------------
`define GAOC_UA_FAULT 16'h01F4
`define GAOC_UA_2MA5 16'h09C4
`define GAOC_UA_4MA 16'h0FA0
`define GAOC_UA_20MA 16'h4E20
`define GAOC_UA_22MA 16'h55F0
`define GAOC_UA_SPAN 16'h3E80
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define GAOC_CLK_HZ 20000000
`define GAOC_CYC_PER_MS (`GAOC_CLK_HZ / 1000)
`define GAOC_INIT_MS 16'h0064
`endif

// ---- rtl/gaoc_ms_tick.v ----
// gaoc_ms_tick.v: millisecond tick divider
// assumes: free running pclk, async active-low reset
`timescale 1ns/10ps
`include "gaoc_consts.vh"
module gaoc_ms_tick #(
  parameter CYC_PER_MS = `GAOC_CYC_PER_MS
) (
  input wire pclk,
  input wire presetn,
  output reg tick_r
);
  reg [15:0] cnt_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (cnt_r == CYC_PER_MS[15:0] - 16'h0001) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end
endmodule

// ---- rtl/gaoc_top.v ----
// gaoc_top.v: gas alarm, lamps, contact, loop level and suppression
// assumes: apb master on pclk, concentration sampled each cycle
// Function
// [R1] alarm when concentration reaches setpoint
// [R2] contact releases itself below setpoint
// [R3] alarm delay, two seconds, can disable
// [R4] over-scale pattern replaces numeric display
// [R5] green power lamp always lit
// [R6] red lamp lit at or above setpoint
// [R7] contact acts only when alarm used
// [R8] fault lights yellow lamp, shows error
// [R9] fault recovery reruns initial clear
// [R10] detection mode loop proportional 4-20 mA
// [R11] maintenance loop per setting selection
// [R12] init clear, inhibit: 2.5 else 4
// [R13] alarm test live or fixed 4 mA
// [R14] loop output clamped at 22 mA
// [R15] readings below threshold reported zero
// [R16] suppression off in maintenance mode
// [R17] delay restarts when concentration drops
// [R18] fault output overrides every other selection
`timescale 1ns/10ps
`include "gaoc_consts.vh"
module gaoc_top #(
  parameter CONC_W = 16,
  parameter CYC_PER_MS = `GAOC_CYC_PER_MS,
  parameter INIT_MS = `GAOC_INIT_MS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [CONC_W-1:0] conc_in,
  input wire [7:0] fault_code_in,
  input wire fault_in,
  output wire power_lamp,
  output reg alarm_indicator_r,
  output reg fault_lamp_r,
  output reg contact_r,
  output reg over_scale_r,
  output reg error_show_r,
  output reg [7:0] error_code_r,
  output reg [CONC_W-1:0] disp_conc_r,
  output reg [15:0] loop_ua_r
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [9:0] ctrl_r;
  reg [15:0] setpt_r;
  reg [15:0] delay_ms_r;
  reg [6:0] supp_pct_r;
  reg [15:0] full_scale_r;
  reg fault_r;
  reg init_r;
  reg [15:0] init_cnt_r;
  reg [15:0] dly_cnt_r;
  reg alarm_r;
  reg [15:0] hold_ua_r;
  wire ms_tick;
  wire wr_en = psel & penable & pwrite;
  wire rd_hit;
  wire alarm_pend;
  reg map_hit;
  localparam [31:0] CTRL_RST = `GAOC_CTRL_RST;
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  always @* begin
    case (paddr)
      `GAOC_OFF_CTRL, `GAOC_OFF_SETPT, `GAOC_OFF_DELAY, `GAOC_OFF_SUPP,
      `GAOC_OFF_CONC, `GAOC_OFF_STAT, `GAOC_OFF_LOOP, `GAOC_OFF_DISP: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  end
  assign rd_hit = map_hit;
  assign pslverr = psel & penable & ~rd_hit;
  always @* begin
    case (paddr)
      `GAOC_OFF_CTRL: prdata = {24'h000000, ctrl_r[7:0]};
      `GAOC_OFF_SETPT: prdata = {16'h0000, setpt_r};
      `GAOC_OFF_DELAY: prdata = {16'h0000, delay_ms_r};
      `GAOC_OFF_SUPP: prdata = {full_scale_r, 9'h000, supp_pct_r};
      `GAOC_OFF_CONC: prdata = {{(32-CONC_W){1'b0}}, conc_in};
      `GAOC_OFF_STAT: prdata = {26'h0000000, (alarm_pend), over_scale_r, init_r, fault_r, contact_r, alarm_r};
      `GAOC_OFF_LOOP: prdata = {16'h0000, loop_ua_r};
      `GAOC_OFF_DISP: prdata = {{(32-CONC_W){1'b0}}, disp_conc_r};
      default: prdata = 32'h0000_0000;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST[9:0];
      setpt_r <= `GAOC_SETPT_RST;
      delay_ms_r <= `GAOC_DELAY_MS_RST;
      supp_pct_r <= `GAOC_SUPP_PCT_RST;
      full_scale_r <= `GAOC_FULL_SCALE_RST;
    end else begin
      ctrl_r[9:8] <= 2'b00;
      if (wr_en) begin
        case (paddr)
          `GAOC_OFF_CTRL: ctrl_r <= pwdata[9:0];
          `GAOC_OFF_SETPT: setpt_r <= pwdata[15:0];
          `GAOC_OFF_DELAY: delay_ms_r <= pwdata[15:0];
          `GAOC_OFF_SUPP: begin
            supp_pct_r <= pwdata[6:0];
            full_scale_r <= pwdata[31:16];
          end
          default: ;
        endcase
      end
    end
  end
  wire dly_en = ctrl_r[`GAOC_CTRL_DLY_EN];
  wire alm_use = ctrl_r[`GAOC_CTRL_ALM_USE];
  wire maint = ctrl_r[`GAOC_CTRL_MAINT];
  wire inhibit = ctrl_r[`GAOC_CTRL_INHIBIT];
  wire atest = ctrl_r[`GAOC_CTRL_ATEST];
  wire atest_out = ctrl_r[`GAOC_CTRL_ATEST_OUT];
  wire [1:0] msel = ctrl_r[`GAOC_CTRL_MSEL_HI:`GAOC_CTRL_MSEL_LO];
  wire fault_set = ctrl_r[`GAOC_CTRL_FAULT_SET];
  wire fault_clr = ctrl_r[`GAOC_CTRL_FAULT_CLR];
  // ----------------------------------------------------------------
  // millisecond timebase
  // ----------------------------------------------------------------
  gaoc_ms_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_r(ms_tick)
  );
  // ----------------------------------------------------------------
  // fault and initial clear
  // ----------------------------------------------------------------
  wire fault_evt = fault_in | fault_set;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      init_r <= 1'b1;
      init_cnt_r <= 16'h0000;
    end else begin
      if (fault_evt) begin
        fault_r <= 1'b1;
      end else if (fault_clr) begin
        fault_r <= 1'b0;
      end
      if (fault_r & ~fault_evt & fault_clr) begin
        init_r <= 1'b1; // [R9]
        init_cnt_r <= 16'h0000;
      end else if (init_r & ms_tick) begin
        if (init_cnt_r == INIT_MS[15:0] - 16'h0001) begin
          init_r <= 1'b0;
        end
        init_cnt_r <= init_cnt_r + 16'h0001;
      end
    end
  end
  // ----------------------------------------------------------------
  // gas alarm with delay
  // ----------------------------------------------------------------
  wire [15:0] conc16 = conc_in;
  wire at_setpt = conc16 >= setpt_r; // [R1]
  assign alarm_pend = at_setpt & ~alarm_r;
  wire run = ~fault_r & ~init_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_r <= 16'h0000;
      alarm_r <= 1'b0;
    end else if (!at_setpt || !run) begin
      dly_cnt_r <= 16'h0000; // [R17]
      alarm_r <= 1'b0; // [R2]
    end else if (!dly_en) begin
      alarm_r <= 1'b1; // [R3]
    end else if (ms_tick && !alarm_r) begin
      if (dly_cnt_r >= delay_ms_r - 16'h0001) begin
        alarm_r <= 1'b1; // [R3] [R17]
      end
      dly_cnt_r <= dly_cnt_r + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // lamps, contact, display
  // ----------------------------------------------------------------
  assign power_lamp = 1'b1; // [R5]
  wire [22:0] supp_prod = full_scale_r * supp_pct_r;
  wire [22:0] supp_q = supp_prod / 23'd100;
  wire [15:0] supp_thr = supp_q[15:0];
  wire over = conc16 > full_scale_r;
  wire [CONC_W-1:0] supp_conc;
  assign supp_conc = (!maint && conc16 < supp_thr) ? {CONC_W{1'b0}} : conc_in; // [R15] [R16]
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_indicator_r <= 1'b0;
      contact_r <= 1'b0;
      fault_lamp_r <= 1'b0;
      error_show_r <= 1'b0;
      error_code_r <= 8'h00;
      over_scale_r <= 1'b0;
      disp_conc_r <= {CONC_W{1'b0}};
    end else begin
      alarm_indicator_r <= alarm_r; // [R6]
      contact_r <= alarm_r & alm_use; // [R7] [R2]
      fault_lamp_r <= fault_r; // [R8]
      error_show_r <= fault_r; // [R8]
      if (fault_evt) begin
        error_code_r <= fault_code_in; // [R8]
      end
      over_scale_r <= over; // [R4]
      disp_conc_r <= over ? {CONC_W{1'b1}} : supp_conc; // [R4]
    end
  end
  // ----------------------------------------------------------------
  // loop output level
  // ----------------------------------------------------------------
  wire [31:0] span_prod = conc16 * `GAOC_UA_SPAN;
  wire [31:0] span_q = span_prod / {16'h0000, full_scale_r};
  wire [31:0] live_wide = span_q + {16'h0000, `GAOC_UA_4MA};
  wire [15:0] live_ua = (live_wide > {16'h0000, `GAOC_UA_22MA}) ? `GAOC_UA_22MA : live_wide[15:0]; // [R14]
  reg [15:0] loop_nxt;
  always @* begin
    loop_nxt = live_ua; // [R10]
    if (fault_r) begin
      loop_nxt = `GAOC_UA_FAULT; // [R18]
    end else if (init_r || inhibit) begin
      loop_nxt = (msel == `GAOC_MSEL_2MA5) ? `GAOC_UA_2MA5 : `GAOC_UA_4MA; // [R12]
    end else if (atest) begin
      loop_nxt = atest_out ? live_ua : `GAOC_UA_4MA; // [R13]
    end else if (maint) begin
      case (msel)
        `GAOC_MSEL_2MA5: loop_nxt = `GAOC_UA_2MA5; // [R11]
        `GAOC_MSEL_4MA: loop_nxt = `GAOC_UA_4MA; // [R11]
        `GAOC_MSEL_HOLD: loop_nxt = hold_ua_r; // [R11]
        default: loop_nxt = live_ua; // [R11]
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_ua_r <= `GAOC_UA_4MA;
      hold_ua_r <= `GAOC_UA_4MA;
    end else begin
      loop_ua_r <= loop_nxt;
      if (!maint) begin
        hold_ua_r <= loop_nxt;
      end
    end
  end
endmodule

// ---- dv/gaoc_top_check_properties.sv ----
// gaoc_top_check_properties.sv: port-level assertions for gaoc_top
// assumes: bound to gaoc_top, one pclk domain, async active-low reset
`timescale 1ns/10ps
module gaoc_top_check #(
  parameter CONC_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire fault_in,
  input wire power_lamp,
  input wire alarm_indicator_r,
  input wire fault_lamp_r,
  input wire contact_r,
  input wire over_scale_r,
  input wire error_show_r,
  input wire [CONC_W-1:0] disp_conc_r,
  input wire [15:0] loop_ua_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fault_held; fault_lamp_r [*3]; endsequence
  sequence s_clean; !fault_lamp_r [*3]; endsequence
  property p_power; power_lamp; endproperty
  property p_contact; contact_r |-> alarm_indicator_r; endproperty
  property p_release; $fell(alarm_indicator_r) |-> !contact_r; endproperty
  property p_clamp; loop_ua_r <= 16'h55F0; endproperty
  property p_fault_loop; s_fault_held |-> loop_ua_r == 16'h01F4; endproperty
  property p_floor; s_clean |-> loop_ua_r >= 16'h09C4; endproperty
  property p_fault_show; fault_lamp_r |-> error_show_r; endproperty
  property p_fault_rise; fault_in |-> ##[0:3] fault_lamp_r; endproperty
  property p_over; over_scale_r |-> disp_conc_r == {CONC_W{1'b1}}; endproperty
  a_power: assert property (p_power) else $error("power lamp dark");
  a_contact: assert property (p_contact) else $error("contact without alarm");
  a_release: assert property (p_release) else $error("contact held after alarm fell");
  a_clamp: assert property (p_clamp) else $error("loop above ceiling");
  a_fault_loop: assert property (p_fault_loop) else $error("fault loop level wrong");
  a_floor: assert property (p_floor) else $error("loop below floor without fault");
  a_fault_show: assert property (p_fault_show) else $error("fault without error display");
  a_fault_rise: assert property (p_fault_rise) else $error("fault lamp late");
  a_over: assert property (p_over) else $error("over-scale pattern missing");
endmodule

bind gaoc_top gaoc_top_check #(.CONC_W(CONC_W)) u_chk (.pclk(pclk), .presetn(presetn), .fault_in(fault_in),
  .power_lamp(power_lamp), .alarm_indicator_r(alarm_indicator_r), .fault_lamp_r(fault_lamp_r),
  .contact_r(contact_r), .over_scale_r(over_scale_r), .error_show_r(error_show_r),
  .disp_conc_r(disp_conc_r), .loop_ua_r(loop_ua_r));

// ---- dv/gaoc_loop_rx.sv ----
// gaoc_loop_rx.sv: upper monitor on the current loop
// assumes: loop level in microamps, sampled on pclk
`timescale 1ns/10ps
module gaoc_loop_rx (
  input wire pclk,
  input wire presetn,
  input wire [15:0] loop_ua,
  output reg fault_seen_r
);
  // below 1 mA the monitor flags a head fault
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_seen_r <= 1'b0;
    else fault_seen_r <= (loop_ua < 16'h03E8);
  end
endmodule

// ---- dv/gaoc_bench.sv ----
// gaoc_bench.sv: self-checking bench for gaoc_top
// assumes: short ms divider and init clear set by parameters
`timescale 1ns/10ps
`include "gaoc_consts.vh"
module gaoc_bench;
  logic pclk, presetn, psel, penable, pwrite, fault_in, pready, pslverr, power_lamp, alarm_indicator, flamp, contact;
  logic over, eshow, rx_fault, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] conc_in, disp, loop_ua;
  logic [7:0] fault_code_in, ecode;
  int num_errors, n_checks, i;
  // conc, disp, loop, alarm
  logic [51:0] rows [0:7] = '{52'h0000_0000_0FA0_0, 52'h063F_0000_15DF_0, 52'h0640_0640_15E0_0,
    52'h0F9F_0F9F_1F3F_0, 52'h0FA0_0FA0_1F40_1, 52'h3E80_3E80_4E20_1, 52'h4E20_FFFF_55F0_1, 52'h0000_0000_0FA0_0};
  // control word, loop level with conc 2000
  logic [31:0] modes [0:6] = '{32'h0004_09C4, 32'h0044_0FA0, 32'h00C4_1770, 32'h0008_09C4, 32'h00C8_0FA0,
    32'h0010_0FA0, 32'h0030_1770};
  gaoc_top #(.CYC_PER_MS(20), .INIT_MS(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conc_in(conc_in), .fault_code_in(fault_code_in), .fault_in(fault_in), .power_lamp(power_lamp),
    .alarm_indicator_r(alarm_indicator), .fault_lamp_r(flamp), .contact_r(contact), .over_scale_r(over),
    .error_show_r(eshow), .error_code_r(ecode), .disp_conc_r(disp), .loop_ua_r(loop_ua));
  gaoc_loop_rx u_rx (.pclk(pclk), .presetn(presetn), .loop_ua(loop_ua), .fault_seen_r(rx_fault));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, fault_in, presetn} = 0; paddr = 0; pwdata = 0; conc_in = 0; fault_code_in = 8'h5A;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    chk("loop_rst", loop_ua, 32'h0FA0);
    chk("power", power_lamp, 32'h1);
    apb(0, `GAOC_OFF_CTRL, 0); chk("ctrl_rst", rd, 32'h43);
    apb(0, `GAOC_OFF_SUPP, 0); chk("supp_rst", rd, 32'hFFFF000A);
    repeat (100) @(posedge pclk);
    apb(1, `GAOC_OFF_SUPP, 32'h3E80000A);
    apb(1, `GAOC_OFF_CTRL, 32'h2);
    for (i = 0; i < 8; i++) begin
      conc_in <= rows[i][51:36];
      settle();
      chk("disp", disp, rows[i][35:20]);
      chk("loop", loop_ua, rows[i][19:4]);
      chk("alarm", alarm_indicator, rows[i][0]);
      chk("contact", contact, rows[i][0]);
      chk("over", over, rows[i][35:20] == 16'hFFFF);
    end
    apb(1, `GAOC_OFF_CTRL, 32'h0); conc_in <= 16'h1388; settle();
    chk("unused_contact", contact, 32'h0);
    conc_in <= 0; apb(1, `GAOC_OFF_DELAY, 32'h3); apb(1, `GAOC_OFF_CTRL, 32'h3); settle();
    conc_in <= 16'h1388; repeat (45) @(posedge pclk);
    chk("delay_early", alarm_indicator, 32'h0);
    conc_in <= 0; @(posedge pclk); conc_in <= 16'h1388; repeat (45) @(posedge pclk);
    chk("delay_restart", alarm_indicator, 32'h0);
    repeat (60) @(posedge pclk);
    chk("delay_done", alarm_indicator, 32'h1);
    conc_in <= 16'h03E8; apb(1, `GAOC_OFF_CTRL, 32'h2); settle();
    chk("supp", disp, 32'h0);
    apb(1, `GAOC_OFF_CTRL, 32'h84); conc_in <= 16'h0320; settle();
    chk("hold", loop_ua, 32'h1388);
    chk("maint_disp", disp, 32'h0320);
    conc_in <= 16'h07D0;
    for (i = 0; i < 7; i++) begin
      apb(1, `GAOC_OFF_CTRL, {16'h0, modes[i][31:16]}); settle();
      chk("mode_loop", loop_ua, modes[i][15:0]);
    end
    apb(1, `GAOC_OFF_CTRL, 32'h2); fault_in <= 1; settle();
    chk("flamp", flamp, 32'h1);
    chk("eshow", eshow, 32'h1);
    chk("ecode", ecode, 32'h5A);
    chk("fault_loop", rx_fault, 32'h1);
    fault_in <= 0; apb(1, `GAOC_OFF_CTRL, 32'h202); settle();
    apb(0, `GAOC_OFF_STAT, 0); chk("init_again", rd[3], 32'h1);
    chk("init_loop", loop_ua, 32'h09C4);
    apb(0, 12'h020, 0); chk("unmapped", {rd[30:0], err}, 32'h1);
    wrap_up();
  end
endmodule
